/* File: logic/typec_dfp_attach_fsm.sv */
// design: configuration select and downstream facing port attach state machine
`timescale 1ns/1ns
// Summary of operation
// - sample config level once after reset
// - dfp follows config profile changes anytime
// - dfp never returns to ufp until reset
// - high config level at power-on selects ufp
// - decode config level into three dfp profiles
// - classify cc open, sink, cable per profile
// - disabled or invalid config: idle, defaults
// - enabled idle watches cc, default outputs
// - sink on cc1 only: supply on
// - sink cc1, cable cc2: power cc2
// - sink on cc2 only: supply, orientation low
// - sink cc2, cable cc1: power cc1
// - cable on both lines: audio flag
// - grounded cc lines count as cable termination
// - overcurrent in dfp mode forces fault state and flag
// - cable power holds until opposite sink leaves
module typec_dfp_attach_fsm (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // analog samples, millivolts, from on-chip adc on clk
    input wire logic [typec_dfp_pkg::MV_W-1:0] cfg_sel_mv,
    input wire logic [typec_dfp_pkg::MV_W-1:0] cc1_mv,
    input wire logic [typec_dfp_pkg::MV_W-1:0] cc2_mv,
    // digital pins
    input wire logic port_enable,
    input wire logic overcurrent_sense_n,
    // port controls
    output logic vbus_supply_enable,
    output logic plug_orientation_n,
    output logic cc1_cable_power_n,
    output logic cc2_cable_power_n,
    output logic audio_adapter,
    // status
    output logic fault_flag_out,
    output logic ufp_mode
);

    // ---------------------------------------------------------------
    // state encoding
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_WAIT_SAMPLE,     // first cycle after reset, nothing chosen yet
        ST_UFP,             // upstream mode, dfp outputs parked
        ST_DISABLED,
        ST_ENABLED_IDLE,
        ST_UNFLIP_PASSIVE,
        ST_UNFLIP_ACTIVE,
        ST_FLIP_PASSIVE,
        ST_FLIP_ACTIVE,
        ST_AUDIO,
        ST_FAULT
    } state_t;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] enable_sync_reg;   // [0] first stage only feeds [1]
    logic [1:0] ocs_sync_reg;      // idles high
    logic enable_prev_reg;         // for falling edge detection

    // synchronise the two digital pins
    always_ff @(posedge clk) begin
        if (rst) begin
            enable_sync_reg <= 2'h0;
            ocs_sync_reg <= 2'h3;
            enable_prev_reg <= 1'b0;
        end else begin
            enable_sync_reg <= {enable_sync_reg[0], port_enable};
            ocs_sync_reg <= {ocs_sync_reg[0], overcurrent_sense_n};
            enable_prev_reg <= enable_sync_reg[1];
        end
    end

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire logic enabled = enable_sync_reg[1];
    wire logic overcurrent = ~ocs_sync_reg[1];
    wire logic enable_fall = enable_prev_reg & ~enabled;
    wire logic ufp_level = (cfg_sel_mv >= typec_dfp_pkg::CFG_UFP_MIN);
    // live profile, followed at any time while in dfp mode
    wire typec_dfp_pkg::profile_t profile = typec_dfp_pkg::decode_profile(cfg_sel_mv);
    wire logic cfg_valid = (profile != typec_dfp_pkg::PROF_NONE);
    wire logic run_ok = enabled & cfg_valid;
    // a grounded line reads 0 mV and lands in the cable band
    wire typec_dfp_pkg::cc_class_t cc1_class = typec_dfp_pkg::classify_cc(cc1_mv, profile);
    wire typec_dfp_pkg::cc_class_t cc2_class = typec_dfp_pkg::classify_cc(cc2_mv, profile);
    wire logic cc1_sink = (cc1_class == typec_dfp_pkg::CC_SINK);
    wire logic cc2_sink = (cc2_class == typec_dfp_pkg::CC_SINK);
    wire logic cc1_cable = (cc1_class == typec_dfp_pkg::CC_CABLE);
    wire logic cc2_cable = (cc2_class == typec_dfp_pkg::CC_CABLE);

    // ---------------------------------------------------------------
    // attach selection from the current cc picture
    // ---------------------------------------------------------------
    state_t state_reg;
    state_t state_next;
    state_t attach_pick;

    // pick the connected state matching both lines; cc1 sink wins a tie
    always_comb begin
        if (cc1_sink && cc2_cable) begin
            attach_pick = ST_UNFLIP_ACTIVE;
        end else if (cc1_sink) begin
            attach_pick = ST_UNFLIP_PASSIVE;
        end else if (cc2_sink && cc1_cable) begin
            attach_pick = ST_FLIP_ACTIVE;
        end else if (cc2_sink) begin
            attach_pick = ST_FLIP_PASSIVE;
        end else if (cc1_cable && cc2_cable) begin
            attach_pick = ST_AUDIO;
        end else begin
            attach_pick = ST_ENABLED_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT_SAMPLE: begin
                // single sample of the config level after reset
                state_next = ufp_level ? ST_UFP : ST_DISABLED;
            end
            ST_UFP: begin
                state_next = ST_UFP;
            end
            ST_FAULT: begin
                // resume once the overcurrent pin releases
                if (!overcurrent) begin
                    state_next = ST_DISABLED;
                end
            end
            ST_DISABLED: begin
                if (run_ok) begin
                    state_next = ST_ENABLED_IDLE;
                end
            end
            ST_ENABLED_IDLE: begin
                state_next = attach_pick;
            end
            ST_UNFLIP_ACTIVE: begin
                // cc2 power held while cc1 sink stays
                state_next = cc1_sink ? ST_UNFLIP_ACTIVE : attach_pick;
            end
            ST_FLIP_ACTIVE: begin
                // cc1 power held while cc2 sink stays
                state_next = cc2_sink ? ST_FLIP_ACTIVE : attach_pick;
            end
            ST_UNFLIP_PASSIVE, ST_FLIP_PASSIVE, ST_AUDIO: begin
                state_next = attach_pick;
            end
            default: begin
                state_next = ST_DISABLED;
            end
        endcase
        // dfp-wide overrides; ufp is never left and never entered here
        if (state_reg != ST_WAIT_SAMPLE && state_reg != ST_UFP) begin
            if (overcurrent) begin
                state_next = ST_FAULT;
            end else if (state_reg != ST_FAULT && !run_ok) begin
                state_next = ST_DISABLED;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_WAIT_SAMPLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // output decode per state
    // ---------------------------------------------------------------
    typec_dfp_pkg::port_ctrl_t ctrl_next;
    typec_dfp_pkg::port_ctrl_t ctrl_reg;

    // output bundle that belongs to the next state
    always_comb begin
        ctrl_next = typec_dfp_pkg::CTRL_DEFAULT;
        case (state_next)
            ST_UNFLIP_PASSIVE: begin
                ctrl_next.vbus_supply_enable = 1'b1;
            end
            ST_UNFLIP_ACTIVE: begin
                ctrl_next.vbus_supply_enable = 1'b1;
                ctrl_next.cc2_cable_power_n = 1'b0;
            end
            ST_FLIP_PASSIVE: begin
                ctrl_next.vbus_supply_enable = 1'b1;
                ctrl_next.plug_orientation_n = 1'b0;
            end
            ST_FLIP_ACTIVE: begin
                ctrl_next.vbus_supply_enable = 1'b1;
                ctrl_next.plug_orientation_n = 1'b0;
                ctrl_next.cc1_cable_power_n = 1'b0;
            end
            ST_AUDIO: begin
                ctrl_next.audio_adapter = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // ---------------------------------------------------------------
    // registered outputs and fault flag
    // ---------------------------------------------------------------
    logic fault_reg;         // internal overcurrent flag, drives fault output
    logic ufp_reg;

    // outputs change with the state they belong to
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= typec_dfp_pkg::CTRL_DEFAULT;
            ufp_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            ufp_reg <= (state_next == ST_UFP);
        end
    end

    // sticky fault, cleared by a falling edge of enable; a new event wins
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_reg <= 1'b0;
        end else if (state_next == ST_FAULT) begin
            fault_reg <= 1'b1;
        end else if (enable_fall) begin
            fault_reg <= 1'b0;
        end
    end

    assign vbus_supply_enable = ctrl_reg.vbus_supply_enable;
    assign plug_orientation_n = ctrl_reg.plug_orientation_n;
    assign cc1_cable_power_n = ctrl_reg.cc1_cable_power_n;
    assign cc2_cable_power_n = ctrl_reg.cc2_cable_power_n;
    assign audio_adapter = ctrl_reg.audio_adapter;
    assign fault_flag_out = fault_reg;
    assign ufp_mode = ufp_reg;

endmodule // typec_dfp_attach_fsm

/* File: inc/typec_dfp_pkg.sv */
// package: constants, types and decode helpers for the type-c dfp attach logic
package typec_dfp_pkg;

    // -------------------------------------------------------------
    // analog sample format
    // -------------------------------------------------------------
    localparam int MV_W = 13;                 // adc samples in millivolts

    // -------------------------------------------------------------
    // configuration select windows (mV)
    // -------------------------------------------------------------
    localparam logic [MV_W-1:0] CFG_UFP_MIN = 13'h06d6;   // 1750
    localparam logic [MV_W-1:0] CFG_3A_MIN = 13'h04b0;    // 1200
    localparam logic [MV_W-1:0] CFG_3A_MAX = 13'h0514;    // 1300
    localparam logic [MV_W-1:0] CFG_1A5_MIN = 13'h02bc;   // 700
    localparam logic [MV_W-1:0] CFG_1A5_MAX = 13'h0320;   // 800
    localparam logic [MV_W-1:0] CFG_LEG_MAX = 13'h012c;   // 300

    // -------------------------------------------------------------
    // cc classification windows per profile (mV)
    // -------------------------------------------------------------
    localparam logic [MV_W-1:0] CC_3A_OPEN_MIN = 13'h0abe;  // 2750
    localparam logic [MV_W-1:0] CC_3A_RD_MAX = 13'h0a28;    // 2600
    localparam logic [MV_W-1:0] CC_3A_RD_MIN = 13'h0352;    // 850
    localparam logic [MV_W-1:0] CC_3A_RA_MAX = 13'h0320;    // 800
    localparam logic [MV_W-1:0] CC_1A5_OPEN_MIN = 13'h0672; // 1650
    localparam logic [MV_W-1:0] CC_1A5_RD_MAX = 13'h0640;   // 1600
    localparam logic [MV_W-1:0] CC_1A5_RD_MIN = 13'h01c2;   // 450
    localparam logic [MV_W-1:0] CC_1A5_RA_MAX = 13'h0190;   // 400
    localparam logic [MV_W-1:0] CC_LEG_OPEN_MIN = 13'h0672; // 1650
    localparam logic [MV_W-1:0] CC_LEG_RD_MAX = 13'h0640;   // 1600
    localparam logic [MV_W-1:0] CC_LEG_RD_MIN = 13'h00fa;   // 250
    localparam logic [MV_W-1:0] CC_LEG_RA_MAX = 13'h00c8;   // 200

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        PROF_NONE,
        PROF_3A,
        PROF_1A5,
        PROF_LEGACY
    } profile_t;

    typedef enum logic [1:0] {
        CC_OPEN,      // open or between bands
        CC_SINK,      // rd sink termination
        CC_CABLE      // ra cable termination or ground
    } cc_class_t;

    // the five port control outputs as one bundle
    typedef struct packed {
        logic vbus_supply_enable;
        logic plug_orientation_n;
        logic cc1_cable_power_n;
        logic cc2_cable_power_n;
        logic audio_adapter;
    } port_ctrl_t;

    localparam port_ctrl_t CTRL_DEFAULT = 5'h0e;   // vbus 0, orient 1, pwr 1/1, audio 0

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // profile from a configuration select sample
    function automatic profile_t decode_profile(input logic [MV_W-1:0] mv);
        if (mv >= CFG_3A_MIN && mv <= CFG_3A_MAX) begin
            return PROF_3A;
        end else if (mv >= CFG_1A5_MIN && mv <= CFG_1A5_MAX) begin
            return PROF_1A5;
        end else if (mv <= CFG_LEG_MAX) begin
            return PROF_LEGACY;
        end
        return PROF_NONE;
    endfunction

    // classify one cc sample under the current profile
    function automatic cc_class_t classify_cc(input logic [MV_W-1:0] mv, input profile_t p);
        logic [MV_W-1:0] rd_hi;
        logic [MV_W-1:0] rd_lo;
        logic [MV_W-1:0] ra_hi;
        rd_hi = CC_LEG_RD_MAX;
        rd_lo = CC_LEG_RD_MIN;
        ra_hi = CC_LEG_RA_MAX;
        case (p)
            PROF_3A: begin
                rd_hi = CC_3A_RD_MAX;
                rd_lo = CC_3A_RD_MIN;
                ra_hi = CC_3A_RA_MAX;
            end
            PROF_1A5: begin
                rd_hi = CC_1A5_RD_MAX;
                rd_lo = CC_1A5_RD_MIN;
                ra_hi = CC_1A5_RA_MAX;
            end
            default: begin
            end
        endcase
        if (p == PROF_NONE) begin
            return CC_OPEN;
        end else if (mv <= ra_hi) begin
            return CC_CABLE;
        end else if (mv >= rd_lo && mv <= rd_hi) begin
            return CC_SINK;
        end
        return CC_OPEN;
    endfunction

endpackage

/* File: bench/typec_dfp_assertions.sv */
// checker: port assertions for the dfp attach logic
`timescale 1ns/1ns
module typec_dfp_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // samples and pins
    input wire logic [12:0] cfg_sel_mv,
    input wire logic [12:0] cc1_mv,
    input wire logic [12:0] cc2_mv,
    input wire logic port_enable,
    input wire logic overcurrent_sense_n,
    // controls and status
    input wire logic vbus_supply_enable,
    input wire logic plug_orientation_n,
    input wire logic cc1_cable_power_n,
    input wire logic cc2_cable_power_n,
    input wire logic audio_adapter,
    input wire logic fault_flag_out,
    input wire logic ufp_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // controls as one word
    wire logic [4:0] ctrl = {vbus_supply_enable, plug_orientation_n, cc1_cable_power_n,
        cc2_cable_power_n, audio_adapter};
    wire logic idle = ctrl == typec_dfp_pkg::CTRL_DEFAULT;  // every control inactive
    // edges since reset, saturating
    logic [2:0] since_rst_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            since_rst_reg <= 3'h0;
        end else if (since_rst_reg != 3'h4) begin
            since_rst_reg <= since_rst_reg + 3'h1;
        end
    end
    // ------
    // sequences
    // ------
    sequence oc_held;
        !overcurrent_sense_n [*5];
    endsequence
    // six cycles cover the worst path: pin sync, fault exit, idle, attach
    sequence cc1_sink_only;
        (port_enable && overcurrent_sense_n && !ufp_mode && cfg_sel_mv >= 13'h04b0
            && cfg_sel_mv <= 13'h0514 && cc1_mv >= 13'h0352 && cc1_mv <= 13'h0a28
            && cc2_mv >= 13'h0abe) [*6];
    endsequence
    sequence lines_open;
        (cc1_mv >= 13'h0abe && cc2_mv >= 13'h0abe) [*3];
    endsequence
    // ------
    // assertions
    // ------
    a_ufp_ports_idle: assert property (ufp_mode |-> idle)
        else $error("controls active in upstream mode");
    a_mode_locked: assert property (since_rst_reg == 3'h4 |-> $stable(ufp_mode))
        else $error("mode changed after power-on");
    a_vbus_no_audio: assert property (vbus_supply_enable |-> !audio_adapter)
        else $error("supply and audio flag together");
    a_orient_has_vbus: assert property (!plug_orientation_n |-> vbus_supply_enable)
        else $error("flipped without supply");
    a_power_one_side: assert property (
        (!cc1_cable_power_n || !cc2_cable_power_n) |-> vbus_supply_enable
        && cc1_cable_power_n != cc2_cable_power_n && cc1_cable_power_n == plug_orientation_n)
        else $error("cable power on wrong line");
    a_fault_forces: assert property (oc_held |-> fault_flag_out && idle)
        else $error("overcurrent did not force fault");
    a_fault_cause: assert property ($rose(fault_flag_out) |-> !$past(overcurrent_sense_n, 2)
        || !$past(overcurrent_sense_n, 3) || !$past(overcurrent_sense_n, 4))
        else $error("fault flag without overcurrent");
    a_fault_sticky: assert property ((port_enable [*4] ##0 fault_flag_out) |=> fault_flag_out)
        else $error("fault flag dropped");
    a_sink_attach: assert property (cc1_sink_only |-> vbus_supply_enable && plug_orientation_n)
        else $error("cc1 sink not attached");
    a_detach_idle: assert property (lines_open |-> idle)
        else $error("open lines not idle");
endmodule // typec_dfp_assertions

bind typec_dfp_attach_fsm typec_dfp_assertions u_chk (
    .clk(clk), .rst(rst), .cfg_sel_mv(cfg_sel_mv), .cc1_mv(cc1_mv), .cc2_mv(cc2_mv),
    .port_enable(port_enable), .overcurrent_sense_n(overcurrent_sense_n),
    .vbus_supply_enable(vbus_supply_enable), .plug_orientation_n(plug_orientation_n),
    .cc1_cable_power_n(cc1_cable_power_n), .cc2_cable_power_n(cc2_cable_power_n),
    .audio_adapter(audio_adapter), .fault_flag_out(fault_flag_out), .ufp_mode(ufp_mode)
);

/* File: bench/typec_sink_model.sv */
// partner: cable and sink loads on the two cc lines
`timescale 1ns/1ns
module typec_sink_model (
    // clock
    input wire logic clk,
    // load per line: 0 open, 1 sink, 2 cable, 3 grounded
    input wire logic [1:0] att1,
    input wire logic [1:0] att2,
    input wire typec_dfp_pkg::profile_t prof,
    // line levels in mV
    output logic [12:0] cc1_mv,
    output logic [12:0] cc2_mv
);
    // sink band and cable ceiling, indexed by profile
    logic [12:0] rd_lo [4] = '{13'h00fa, 13'h0352, 13'h01c2, 13'h00fa};
    logic [12:0] rd_hi [4] = '{13'h0640, 13'h0a28, 13'h0640, 13'h0640};
    logic [12:0] ra_hi [4] = '{13'h00c8, 13'h0320, 13'h0190, 13'h00c8};
    // fresh random level in the band of a sink or cable load, every cycle; open and grounded lines get fixed levels
    function automatic logic [12:0] level(input logic [1:0] a, input logic [1:0] p);
        case (a)
            2'h0: return 13'h1388;  // released line sits at the pull-up
            2'h1: return rd_lo[p] + 13'($urandom % (rd_hi[p] - rd_lo[p] + 13'h1));
            2'h2: return 13'h0001 + 13'($urandom % ra_hi[p]);
            default: return 13'h0000;
        endcase
    endfunction
    // levels move off the sampling edge; one process drives both lines
    always @(negedge clk) begin
        cc1_mv <= level(att1, prof);
        cc2_mv <= level(att2, prof);
    end
endmodule // typec_sink_model

/* File: bench/testbench.sv */
// testbench: self-checking bench for the dfp attach logic
`timescale 1ns/1ns
module testbench;
    // ------
    // signals
    // ------
    typedef struct { string name; logic [6:0] val; } note_t;  // expected outputs
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] cfg_sel_mv;
    logic [12:0] cc1_mv;
    logic [12:0] cc2_mv;
    logic port_enable = 1'b0;
    logic overcurrent_sense_n = 1'b1;
    logic [1:0] att1 = 2'h0;  // far-side load per line
    logic [1:0] att2 = 2'h0;
    typec_dfp_pkg::profile_t prof = typec_dfp_pkg::PROF_3A;
    wire typec_dfp_pkg::port_ctrl_t ctrl;
    wire logic fault_flag_out;
    wire logic ufp_mode;
    logic fl = 1'b0;  // expected fault flag
    logic up = 1'b0;  // expected upstream mode
    note_t notes[$];
    event look;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int p;
    int i;
    // controls: vbus, orient_n, pwr1_n, pwr2_n, audio
    localparam logic [4:0] def_ctrl = 5'h0e;
    logic [1:0] combo_a1 [7] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h0};
    logic [1:0] combo_a2 [7] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [4:0] combo_exp [7] = '{5'h1e, 5'h1c, 5'h16, 5'h12, 5'h0f, 5'h0f, 5'h0e};
    initial begin
        forever #25 clk = ~clk;
    end
    typec_dfp_attach_fsm DUT (
        .clk(clk), .rst(rst), .cfg_sel_mv(cfg_sel_mv), .cc1_mv(cc1_mv), .cc2_mv(cc2_mv),
        .port_enable(port_enable), .overcurrent_sense_n(overcurrent_sense_n),
        .vbus_supply_enable(ctrl.vbus_supply_enable),
        .plug_orientation_n(ctrl.plug_orientation_n),
        .cc1_cable_power_n(ctrl.cc1_cable_power_n),
        .cc2_cable_power_n(ctrl.cc2_cable_power_n),
        .audio_adapter(ctrl.audio_adapter), .fault_flag_out(fault_flag_out),
        .ufp_mode(ufp_mode)
    );
    typec_sink_model u_sink (
        .clk(clk), .att1(att1), .att2(att2), .prof(prof), .cc1_mv(cc1_mv), .cc2_mv(cc2_mv)
    );
    // ------
    // tasks
    // ------
    // random config level inside a profile window
    function automatic logic [12:0] cfg_for(input typec_dfp_pkg::profile_t pr);
        case (pr)
            typec_dfp_pkg::PROF_3A: return 13'h04b0 + 13'($urandom % 101);
            typec_dfp_pkg::PROF_1A5: return 13'h02bc + 13'($urandom % 101);
            default: return 13'($urandom % 301);
        endcase
    endfunction
    task automatic check(input string nm, input logic [6:0] got, input logic [6:0] ex);
        check_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // apply loads, let them settle, note the expected outputs
    task automatic step(input string nm, input logic [1:0] a1, input logic [1:0] a2,
            input logic [4:0] c);
        att1 = a1;
        att2 = a2;
        repeat (6) @(negedge clk);
        notes.push_back('{nm, {c, fl, up}});
        -> look;
    endtask
    task automatic power_on(input logic [12:0] cfg);
        rst = 1'b1;
        port_enable = 1'b0;
        cfg_sel_mv = cfg;
        repeat (4) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watcher: oldest note against the outputs
    always @(look) begin : watch
        note_t n;
        n = notes.pop_front();
        check(n.name, {ctrl, fault_flag_out, ufp_mode}, n.val);
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    // ------
    // tests
    // ------
    initial begin
        void'($urandom(74));
        power_on(cfg_for(typec_dfp_pkg::PROF_3A));
        step("disabled", 2'h1, 2'h0, def_ctrl);
        $display("test disabled done");
        port_enable = 1'b1;
        for (p = 1; p < 4; p++) begin
            prof = typec_dfp_pkg::profile_t'(p);
            cfg_sel_mv = cfg_for(prof);
            for (i = 0; i < 7; i++) begin
                step($sformatf("attach %0d/%0d", p, i), combo_a1[i], combo_a2[i],
                    combo_exp[i]);
            end
        end
        $display("test attach done");
        step("hold on", 2'h1, 2'h2, 5'h1c);
        step("hold off", 2'h1, 2'h0, 5'h1c);
        step("detach", 2'h0, 2'h0, def_ctrl);
        $display("test hold done");
        cfg_sel_mv = 13'h06d6 + 13'($urandom % 3251);
        step("cfg high", 2'h1, 2'h0, def_ctrl);
        cfg_sel_mv = 13'h012d + 13'($urandom % 399);
        step("cfg gap", 2'h1, 2'h0, def_ctrl);
        cfg_sel_mv = cfg_for(prof);
        step("cfg back", 2'h1, 2'h0, 5'h1e);
        port_enable = 1'b0;
        step("enable off", 2'h1, 2'h0, def_ctrl);
        port_enable = 1'b1;
        $display("test config done");
        step("flipped", 2'h0, 2'h1, 5'h16);
        overcurrent_sense_n = 1'b0;
        fl = 1'b1;
        step("overcurrent", 2'h0, 2'h1, def_ctrl);
        overcurrent_sense_n = 1'b1;
        step("recovered", 2'h0, 2'h1, 5'h16);
        port_enable = 1'b0;
        fl = 1'b0;
        step("fault cleared", 2'h0, 2'h1, def_ctrl);
        $display("test fault done");
        power_on(13'h06d6 + 13'($urandom % 3251));
        port_enable = 1'b1;
        up = 1'b1;
        step("ufp", 2'h1, 2'h0, def_ctrl);
        cfg_sel_mv = cfg_for(typec_dfp_pkg::PROF_3A);
        step("ufp kept", 2'h1, 2'h0, def_ctrl);
        $display("test ufp done");
        @(negedge clk);
        test_done();
    end
endmodule // testbench
